// *** logic/pmt_consts.vh ***
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH

// Register bus geometry
`define PMT_ADDR_W 4
`define PMT_DATA_W 8

// Register offsets
`define PMT_ADDR_COUNT 4'h0
`define PMT_ADDR_PERIOD 4'h1
`define PMT_ADDR_CONTROL 4'h2
`define PMT_ADDR_FLAG 4'h3
`define PMT_ADDR_IRQ_STATUS 4'h4
`define PMT_ADDR_IRQ_CLEAR 4'h5
`define PMT_ADDR_IRQ_ENABLE 4'h6
`define PMT_ADDR_PRE_STATE 4'h7
`define PMT_ADDR_POST_STATE 4'h8

// Reset values
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CONTROL_RST 8'h00
`define PMT_ZERO8 8'h00

// Control register fields
`define PMT_CTL_PRE_LSB 0
`define PMT_CTL_PRE_MSB 1
`define PMT_CTL_RUN 2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_POST_MSB 6
`define PMT_CTL_IMPL_MASK 8'h7f

// Peripheral flag register: match flag position
`define PMT_FLAG_BIT 1

// Interrupt status, clear and enable layout
`define PMT_EV_W 2
`define PMT_EV_POST 0
`define PMT_EV_MATCH 1
`define PMT_EV_NONE 2'h0

// Instruction clock: one tick every four oscillator clocks
`define PMT_QDIV_W 2
`define PMT_QDIV_LAST 2'h3
`define PMT_QDIV_RST 2'h0

// Prescaler codes and terminal counts
`define PMT_SCL_W 4
`define PMT_SCL_RST 4'h0
`define PMT_SCL_ONE 4'h1
`define PMT_PRE_DIV1 2'h0
`define PMT_PRE_DIV4 2'h1
`define PMT_PRE_LIM1 4'h0
`define PMT_PRE_LIM4 4'h3
`define PMT_PRE_LIM16 4'hf

`endif

// *** logic/pmt_prescaler.v ***
`timescale 1ns/100ps
`include "pmt_consts.vh"
module pmt_prescaler (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire clear,
  input wire run,
  input wire tick,
  input wire [1:0] sel,
  // Result
  output wire pulse,
  output wire [`PMT_SCL_W-1:0] state
);

  reg [`PMT_SCL_W-1:0] cnt_r;
  reg [`PMT_SCL_W-1:0] limit;

  // Code 1x selects divide by 16
  always @* begin
    case (sel)
      `PMT_PRE_DIV1: limit = `PMT_PRE_LIM1;
      `PMT_PRE_DIV4: limit = `PMT_PRE_LIM4;
      default: limit = `PMT_PRE_LIM16;
    endcase
  end

  assign pulse = run & tick & ~clear & (cnt_r == limit);
  assign state = cnt_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `PMT_SCL_RST;
    end else if (clear) begin
      cnt_r <= `PMT_SCL_RST;
    end else if (run && tick) begin
      if (pulse) begin
        cnt_r <= `PMT_SCL_RST;
      end else begin
        cnt_r <= cnt_r + `PMT_SCL_ONE;
      end
    end
  end

endmodule

// *** logic/pmt_postscaler.v ***
`timescale 1ns/100ps
`include "pmt_consts.vh"
module pmt_postscaler (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire clear,
  input wire step,
  input wire [`PMT_SCL_W-1:0] sel,
  // Result
  output wire pulse,
  output wire [`PMT_SCL_W-1:0] state
);

  reg [`PMT_SCL_W-1:0] cnt_r;

  // Code n divides by n+1
  assign pulse = step & ~clear & (cnt_r == sel);
  assign state = cnt_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `PMT_SCL_RST;
    end else if (clear) begin
      cnt_r <= `PMT_SCL_RST;
    end else if (step) begin
      if (pulse) begin
        cnt_r <= `PMT_SCL_RST;
      end else begin
        cnt_r <= cnt_r + `PMT_SCL_ONE;
      end
    end
  end

endmodule

// *** logic/pmt_timer.v ***
// What this block does
// [R1] Timer clocked from instruction clock (clk/4) through prescaler 1, 4 or 16.
// [R2] Control bits 1-0 pick prescale: 00 by 1, 01 by 4, 1x by 16.
// [R3] Count increments once per prescaler pulse from zero, compared to period.
// [R4] On match the next increment loads zero instead of counting up.
// [R5] Each count-period match advances the postscaler once.
// [R6] Control bits 6-3 pick postscale: code n divides by n+1.
// [R7] Each postscaler output sets the match interrupt flag.
// [R8] Count and period fully read/write; reset gives count 00, period ff.
// [R9] Timer runs only while control bit 2 is one.
// [R10] Count write, control write and reset clear prescaler and postscaler.
// [R11] Writing control leaves the count value untouched.
// [R12] Match flag stays set until software writes zero to it.
// [R13] Control bit 7 reads zero and ignores writes.
`timescale 1ns/100ps
`include "pmt_consts.vh"
module pmt_timer #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire nrst,

  // Register port
  input wire [`PMT_ADDR_W-1:0] addr,
  input wire [`PMT_DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [`PMT_DATA_W-1:0] rd_data,

  // Timer outputs
  output reg match_interrupt_flag,
  output reg post_pulse_out,
  output reg irq
);

  // Instruction clock divider
  reg [`PMT_QDIV_W-1:0] qdiv_r;
  wire inst_tick;

  // Software visible state
  reg [CNT_W-1:0] timer_count_r;
  reg [CNT_W-1:0] timer_count_nxt;
  reg [CNT_W-1:0] period_value_r;
  reg [`PMT_DATA_W-1:0] timer_control_r;
  reg flag_r;
  reg flag_nxt;
  reg [`PMT_EV_W-1:0] irq_status_r;
  reg [`PMT_EV_W-1:0] irq_status_nxt;
  reg [`PMT_EV_W-1:0] irq_enable_r;

  // Control fields
  wire run_bit;
  wire [1:0] prescale_select;
  wire [`PMT_SCL_W-1:0] postscale_select;

  // Write decode
  wire wr_count;
  wire wr_period;
  wire wr_control;
  wire wr_flag;
  wire wr_irq_clear;
  wire wr_irq_enable;
  wire scaler_clear;

  // Timer datapath
  wire pre_pulse;
  wire post_pulse;
  wire count_match;
  wire inc_cycle;
  wire match_pulse;
  wire [`PMT_SCL_W-1:0] pre_state;
  wire [`PMT_SCL_W-1:0] post_state;
  wire [`PMT_EV_W-1:0] events;

  // Read path
  reg [`PMT_DATA_W-1:0] rd_mux;

  // ------------------------------------------------------------------
  // Instruction clock: one tick in four oscillator clocks
  // ------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qdiv_r <= `PMT_QDIV_RST;
    end else begin
      qdiv_r <= qdiv_r + {{(`PMT_QDIV_W-1){1'b0}}, 1'b1}; // [R1]
    end
  end

  assign inst_tick = (qdiv_r == `PMT_QDIV_LAST); // [R1]

  // ------------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------------
  assign run_bit = timer_control_r[`PMT_CTL_RUN];
  assign prescale_select =
    timer_control_r[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB];
  assign postscale_select =
    timer_control_r[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB];

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  assign wr_count = wr_en && (addr == `PMT_ADDR_COUNT);
  assign wr_period = wr_en && (addr == `PMT_ADDR_PERIOD);
  assign wr_control = wr_en && (addr == `PMT_ADDR_CONTROL);
  assign wr_flag = wr_en && (addr == `PMT_ADDR_FLAG);
  assign wr_irq_clear = wr_en && (addr == `PMT_ADDR_IRQ_CLEAR);
  assign wr_irq_enable = wr_en && (addr == `PMT_ADDR_IRQ_ENABLE);

  // Reset clears the scaler counters through their own reset
  assign scaler_clear = wr_count | wr_control; // [R10]

  // ------------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------------
  pmt_prescaler u_pre (
    .clk(clk),
    .nrst(nrst),
    .clear(scaler_clear), // [R10]
    .run(run_bit), // [R9]
    .tick(inst_tick), // [R1]
    .sel(prescale_select), // [R2]
    .pulse(pre_pulse),
    .state(pre_state)
  );

  // ------------------------------------------------------------------
  // Count and period comparison
  // ------------------------------------------------------------------
  assign count_match = (timer_count_r == period_value_r); // [R3]

  // A stopped timer takes no increment cycles
  assign inc_cycle = pre_pulse & run_bit; // [R9]

  // Match acts on the increment cycle that wraps the count
  assign match_pulse = inc_cycle & count_match; // [R4]

  always @* begin
    timer_count_nxt = timer_count_r;
    if (wr_count) begin
      timer_count_nxt = wr_data[CNT_W-1:0]; // [R8]
    end else if (match_pulse) begin
      timer_count_nxt = {CNT_W{1'b0}}; // [R4]
    end else if (inc_cycle) begin
      timer_count_nxt = timer_count_r + {{(CNT_W-1){1'b0}}, 1'b1}; // [R3]
    end
  end

  // Control writes never reach the count
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_count_r <= `PMT_COUNT_RST; // [R8]
    end else begin
      timer_count_r <= timer_count_nxt; // [R11]
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_value_r <= `PMT_PERIOD_RST; // [R8]
    end else if (wr_period) begin
      period_value_r <= wr_data[CNT_W-1:0]; // [R8]
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_control_r <= `PMT_CONTROL_RST;
    end else if (wr_control) begin
      timer_control_r <= wr_data & `PMT_CTL_IMPL_MASK; // [R13]
    end
  end

  // ------------------------------------------------------------------
  // Postscaler
  // ------------------------------------------------------------------
  pmt_postscaler u_post (
    .clk(clk),
    .nrst(nrst),
    .clear(scaler_clear), // [R10]
    .step(match_pulse), // [R5]
    .sel(postscale_select), // [R6]
    .pulse(post_pulse),
    .state(post_state)
  );

  // ------------------------------------------------------------------
  // Match interrupt flag
  // ------------------------------------------------------------------
  // Set wins over a clearing write in the same cycle
  always @* begin
    flag_nxt = flag_r;
    if (wr_flag && !wr_data[`PMT_FLAG_BIT]) begin
      flag_nxt = 1'b0; // [R12]
    end
    if (post_pulse) begin
      flag_nxt = 1'b1; // [R7]
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt; // [R12]
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status, clear and enable
  // ------------------------------------------------------------------
  assign events = {match_pulse, post_pulse};

  always @* begin
    irq_status_nxt = irq_status_r;
    if (wr_irq_clear) begin
      irq_status_nxt = irq_status_nxt & ~wr_data[`PMT_EV_W-1:0];
    end
    irq_status_nxt = irq_status_nxt | events;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status_r <= `PMT_EV_NONE;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_enable_r <= `PMT_EV_NONE;
    end else if (wr_irq_enable) begin
      irq_enable_r <= wr_data[`PMT_EV_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      match_interrupt_flag <= 1'b0;
      post_pulse_out <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_enable_r);
      match_interrupt_flag <= flag_r;
      post_pulse_out <= post_pulse; // [R7]
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always @* begin
    rd_mux = `PMT_ZERO8;
    case (addr)
      `PMT_ADDR_COUNT: begin
        rd_mux[CNT_W-1:0] = timer_count_r; // [R8]
      end
      `PMT_ADDR_PERIOD: begin
        rd_mux[CNT_W-1:0] = period_value_r; // [R8]
      end
      `PMT_ADDR_CONTROL: begin
        rd_mux = timer_control_r & `PMT_CTL_IMPL_MASK; // [R13]
      end
      `PMT_ADDR_FLAG: begin
        rd_mux[`PMT_FLAG_BIT] = flag_r;
      end
      `PMT_ADDR_IRQ_STATUS: begin
        rd_mux[`PMT_EV_W-1:0] = irq_status_r;
      end
      `PMT_ADDR_IRQ_ENABLE: begin
        rd_mux[`PMT_EV_W-1:0] = irq_enable_r;
      end
      `PMT_ADDR_PRE_STATE: begin
        rd_mux[`PMT_SCL_W-1:0] = pre_state;
      end
      `PMT_ADDR_POST_STATE: begin
        rd_mux[`PMT_SCL_W-1:0] = post_state;
      end
      default: begin
        rd_mux = `PMT_ZERO8;
      end
    endcase
  end

  // Read data stands for exactly one cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= `PMT_ZERO8;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= `PMT_ZERO8;
    end
  end

endmodule

// *** test/pmt_timer_monitor.sv ***
`timescale 1ns/100ps
`include "pmt_consts.vh"
module pmt_timer_monitor #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [`PMT_ADDR_W-1:0] addr,
  input wire [`PMT_DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [`PMT_DATA_W-1:0] rd_data,
  // Timer outputs
  input wire match_interrupt_flag,
  input wire post_pulse_out,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire flag_wr = wr_en && (addr == `PMT_ADDR_FLAG);
  wire ctl_wr = wr_en && (addr == `PMT_ADDR_CONTROL);
  reg flag_wr_r;
  reg [3:0] stop_cnt_r;
  // Cycles since the run bit was last written as zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_wr_r <= 1'b0;
      stop_cnt_r <= 4'h1;
    end else begin
      flag_wr_r <= flag_wr;
      if (ctl_wr)
        stop_cnt_r <= wr_data[`PMT_CTL_RUN] ? 4'h0 : 4'h1;
      else if (stop_cnt_r != 4'h0 && stop_cnt_r != 4'hf)
        stop_cnt_r <= stop_cnt_r + 4'h1;
    end
  end
  sequence s_wr_rd(a);
    wr_en && addr == a ##1 rd_en && addr == a;
  endsequence
  property p_readback(a, m);
    s_wr_rd(a) |=> rd_data == ($past(wr_data, 2) & m);
  endproperty
  a_cnt_readback:
    assert property (p_readback(`PMT_ADDR_COUNT, 8'hff))
    else $error("count readback differs");
  a_per_readback:
    assert property (p_readback(`PMT_ADDR_PERIOD, 8'hff))
    else $error("period readback differs");
  a_ctl_readback:
    assert property (p_readback(`PMT_ADDR_CONTROL, 8'h7f))
    else $error("control readback differs");
  a_rd_idle_zero:
    assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
  a_flag_sticky:
    assert property (match_interrupt_flag && !flag_wr && !flag_wr_r
      |=> match_interrupt_flag)
    else $error("flag dropped without clear");
  a_post_sets_flag:
    assert property (post_pulse_out |=> match_interrupt_flag)
    else $error("postscaler output without flag");
  a_post_spacing:
    assert property (post_pulse_out |=> !post_pulse_out [*3])
    else $error("postscaler outputs closer than a tick");
  a_stop_silent:
    assert property (stop_cnt_r > 4'h3 |-> !post_pulse_out)
    else $error("output while stopped");
endmodule
bind pmt_timer pmt_timer_monitor #(.CNT_W(CNT_W)) u_mon (.clk(clk),
  .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data),
  .match_interrupt_flag(match_interrupt_flag),
  .post_pulse_out(post_pulse_out), .irq(irq));

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`include "pmt_consts.vh"
module tb_top;
  reg clk, nrst, wr_en, rd_en;
  reg [`PMT_ADDR_W-1:0] addr;
  reg [`PMT_DATA_W-1:0] wr_data;
  wire [`PMT_DATA_W-1:0] rd_data;
  wire match_interrupt_flag, post_pulse_out, irq;
  integer mismatches, num_checks, i, n, p;
  pmt_timer #(.CNT_W(8)) DUT (.clk(clk), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .match_interrupt_flag(match_interrupt_flag),
    .post_pulse_out(post_pulse_out), .irq(irq));
  always #5 clk = ~clk;
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input [7:0] s, input [7:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Strobe stays high so writes can follow back to back
  task wr(input [3:0] a, input [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task idle(input integer c);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (c) @(posedge clk);
  endtask
  task rc(input [3:0] a, input [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk($sformatf("reg %0h", a), rd_data, e);
  endtask
  // Align to the instruction tick via a match, then zero the count
  task sync(input [7:0] per);
    wr(`PMT_ADDR_PERIOD, per);
    wr(`PMT_ADDR_COUNT, per);
    wr(`PMT_ADDR_CONTROL, 8'h04);
    idle(0);
    i = 0;
    while (post_pulse_out !== 1'b1 && i < 40) begin
      @(posedge clk);
      #1 i = i + 1;
    end
    chk("sync", {7'h0, post_pulse_out}, 8'h01);
    wr(`PMT_ADDR_COUNT, 8'h00);
  endtask
  initial begin
    clk = 0;
    nrst = 0;
    addr = 0;
    wr_data = 0;
    wr_en = 0;
    rd_en = 0;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(`PMT_ADDR_COUNT, 8'h00);
    rc(`PMT_ADDR_PERIOD, 8'hff);
    rc(`PMT_ADDR_CONTROL, 8'h00);
    rc(`PMT_ADDR_FLAG, 8'h00);
    $display("reset values done");
    wr(`PMT_ADDR_PERIOD, 8'h5a);
    rc(`PMT_ADDR_PERIOD, 8'h5a);
    wr(`PMT_ADDR_COUNT, 8'h3c);
    rc(`PMT_ADDR_COUNT, 8'h3c);
    wr(`PMT_ADDR_CONTROL, 8'hff);
    rc(`PMT_ADDR_CONTROL, 8'h7f);
    wr(`PMT_ADDR_CONTROL, 8'h00);
    $display("register access done");
    for (p = 0; p < 4; p = p + 1) begin
      sync(8'hff);
      wr(`PMT_ADDR_CONTROL, 8'h04 | p[7:0]);
      n = (p == 0) ? 40 : (p == 1) ? 160 : 640;
      idle(n - 1);
      wr(`PMT_ADDR_CONTROL, 8'h00);
      rc(`PMT_ADDR_COUNT, 8'h0a);
      wr(`PMT_ADDR_CONTROL, 8'h78);
      rc(`PMT_ADDR_COUNT, 8'h0a);
      rc(`PMT_ADDR_PRE_STATE, 8'h00);
      rc(`PMT_ADDR_POST_STATE, 8'h00);
    end
    $display("prescale done");
    for (p = 0; p < 16; p = p + 1) begin
      sync(8'h02);
      wr(`PMT_ADDR_CONTROL, {1'b0, p[3:0], 3'b100});
      idle(0);
      n = 0;
      repeat (24 * p + 28) begin
        @(posedge clk);
        #1;
        if (post_pulse_out === 1'b1)
          n = n + 1;
      end
      chk("posts", n[7:0], 8'h02);
      chk("pin", {7'h0, match_interrupt_flag}, 8'h01);
      wr(`PMT_ADDR_CONTROL, 8'h00);
      rc(`PMT_ADDR_FLAG, 8'h02);
      wr(`PMT_ADDR_FLAG, 8'h02);
      rc(`PMT_ADDR_FLAG, 8'h02);
      wr(`PMT_ADDR_FLAG, 8'h00);
      rc(`PMT_ADDR_FLAG, 8'h00);
    end
    $display("postscale done");
    rc(`PMT_ADDR_IRQ_STATUS, 8'h03);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(`PMT_ADDR_IRQ_ENABLE, 8'h01);
    idle(2);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(`PMT_ADDR_IRQ_CLEAR, 8'h01);
    idle(2);
    chk("irq", {7'h0, irq}, 8'h00);
    rc(`PMT_ADDR_IRQ_STATUS, 8'h02);
    wr(`PMT_ADDR_IRQ_ENABLE, 8'h03);
    idle(2);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(`PMT_ADDR_IRQ_CLEAR, 8'h02);
    wr(`PMT_ADDR_IRQ_STATUS, 8'hff);
    idle(2);
    chk("irq", {7'h0, irq}, 8'h00);
    rc(`PMT_ADDR_IRQ_STATUS, 8'h00);
    rc(`PMT_ADDR_IRQ_CLEAR, 8'h00);
    rc(`PMT_ADDR_IRQ_ENABLE, 8'h03);
    wr(4'hf, 8'hff);
    rc(4'hf, 8'h00);
    $display("interrupts done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    test_done;
  end
endmodule
